/* fpad_pkg.sv */
// Constants, types and encodings for the fixed-point arithmetic datapath.
// Assumes a single pclk domain; the register bus is APB with 32-bit data.
// Behaviour
// - Signed values are twos-complement only
// - ALU treats words as plain 16-bit patterns
// - Logic ops act bitwise, no sign handling
// - Overflow flag follows twos-complement sign rules
// - Carry flag is unsigned carry out of MSB
// - Negative flag reports signed result sign
// - Divide steps interpret operands signed or unsigned
// - Low words unsigned, top word signed
// - Fractional format is one sign, fifteen fractions
// - Multiplier operand signedness chosen per instruction
// - Product sign-extended across 40-bit result
// - Fractional mode shifts product left one bit
// - Integer mode writes product without shift
// - Logical shifts unsigned, arithmetic shifts signed
// - Exponent detection treats input as twos-complement
// - Status captured into status register on each ALU or MAC command
package fpad_pkg;

  // Register byte offsets
  localparam logic [7:0] FPAD_OFF_CMD = 8'h00;
  localparam logic [7:0] FPAD_OFF_OPS = 8'h04;
  localparam logic [7:0] FPAD_OFF_ALU_RES = 8'h08;
  localparam logic [7:0] FPAD_OFF_STATUS = 8'h0c;
  localparam logic [7:0] FPAD_OFF_MULT_LO = 8'h10;
  localparam logic [7:0] FPAD_OFF_MULT_HI = 8'h14;
  localparam logic [7:0] FPAD_OFF_SHF_RES = 8'h18;
  localparam logic [7:0] FPAD_OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] FPAD_OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] FPAD_OFF_MODE = 8'h24;

  // Command word field positions
  localparam int FPAD_CMD_OP_LSB = 0;
  localparam int FPAD_CMD_UNIT_LSB = 8;
  localparam int FPAD_CMD_XS_BIT = 12;
  localparam int FPAD_CMD_YS_BIT = 13;
  localparam int FPAD_CMD_RND_BIT = 14;
  localparam int FPAD_CMD_AMT_LSB = 16;

  // Status register bit positions
  localparam int FPAD_ST_ZERO = 0;
  localparam int FPAD_ST_NEG = 1;
  localparam int FPAD_ST_CARRY = 2;
  localparam int FPAD_ST_OVF = 3;
  localparam int FPAD_ST_XSIGN = 4;
  localparam int FPAD_ST_QUOT = 5;
  localparam int FPAD_ST_MOVF = 6;

  // Reset values and rounding bias
  localparam logic [6:0] FPAD_RST_STATUS = 7'h00;
  localparam logic [1:0] FPAD_RST_IRQ = 2'h0;
  localparam logic FPAD_RST_MODE = 1'b0;
  localparam logic [15:0] FPAD_RND_BIAS = 16'h8000;

  // Interrupt event bits: ALU overflow, multiplier overflow
  localparam int FPAD_IRQ_AOVF = 0;
  localparam int FPAD_IRQ_MOVF = 1;

  // Unit select
  typedef enum logic [3:0] {
    FPAD_UNIT_ALU = 4'h0,
    FPAD_UNIT_MAC = 4'h1,
    FPAD_UNIT_SHF = 4'h2
  } fpad_unit_t;

  // ALU operations
  typedef enum logic [7:0] {
    FPAD_A_ADD = 8'h00, FPAD_A_ADC = 8'h01, FPAD_A_SUB = 8'h02, FPAD_A_SBB = 8'h03,
    FPAD_A_RSUB = 8'h04, FPAD_A_RSBB = 8'h05, FPAD_A_NEGX = 8'h06, FPAD_A_NEGY = 8'h07,
    FPAD_A_INCY = 8'h08, FPAD_A_DECY = 8'h09, FPAD_A_PASSX = 8'h0a, FPAD_A_PASSY = 8'h0b,
    FPAD_A_ZERO = 8'h0c, FPAD_A_ABSX = 8'h0d, FPAD_A_AND = 8'h0e, FPAD_A_OR = 8'h0f,
    FPAD_A_XOR = 8'h10, FPAD_A_NOTX = 8'h11, FPAD_A_NOTY = 8'h12,
    FPAD_A_SIGNED_DIVIDE_STEP = 8'h13, FPAD_A_DIVQ = 8'h14
  } fpad_alu_op_t;

  // MAC operations
  typedef enum logic [7:0] {
    FPAD_M_MUL = 8'h00, FPAD_M_MAC = 8'h01, FPAD_M_MSB = 8'h02, FPAD_M_CLR = 8'h03
  } fpad_mac_op_t;

  // Shifter operations
  typedef enum logic [7:0] {
    FPAD_S_LSH = 8'h00, FPAD_S_ASH = 8'h01, FPAD_S_EXP = 8'h02
  } fpad_shf_op_t;

  // Issued operation, latched from the command register
  typedef struct packed {
    logic [7:0] op;
    fpad_unit_t unit;
    logic x_signed;
    logic y_signed;
    logic round;
    logic [5:0] amount;
  } fpad_cmd_t;

  // Arithmetic status word
  typedef struct packed {
    logic mac_ovf;
    logic quot;
    logic x_sign;
    logic overflow_flag;
    logic carry_flag;
    logic negative_flag;
    logic zero;
  } fpad_status_t;

endpackage

/* fpad_datapath.sv */
// Fixed-point datapath: ALU, multiplier/accumulator and shifter behind an APB slave.
// Assumes one pclk domain; software writes operands then a command, which executes
// in the following cycle.
`timescale 1ns/1ps
module fpad_datapath (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import fpad_pkg::*;

  // Bus strobes
  logic wr_en;
  assign wr_en = psel && penable && pwrite && pready;

  // Software-visible state and the command issue flag
  logic [15:0] x_q;  // X operand
  logic [15:0] y_q;  // Y operand
  logic [15:0] alu_res_q;  // ALU result
  logic [39:0] mult_result_reg_q;  // 40-bit multiplier result
  logic [15:0] shf_res_q;  // Shifter result
  logic [5:0] shf_exp_q;  // Exponent detect result
  fpad_status_t arith_status_reg_q;  // Arithmetic status
  logic [1:0] irq_stat_q;  // Sticky events
  logic [1:0] irq_mask_q;  // Enable per event
  logic frac_mode_q;  // High = fractional multiplier format
  fpad_cmd_t cmd_q;  // Pending command
  logic go_q;  // Command issued last cycle

  // Two-cycle APB: a setup then access with pready set in that access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Operand, mode and command capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      frac_mode_q <= FPAD_RST_MODE;
      cmd_q <= '0;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_en && paddr == FPAD_OFF_OPS) begin
        x_q <= pwdata[15:0];
        y_q <= pwdata[31:16];
      end else if (wr_en && paddr == FPAD_OFF_MODE) begin
        frac_mode_q <= pwdata[0];
      end else if (wr_en && paddr == FPAD_OFF_CMD) begin
        cmd_q.op <= pwdata[FPAD_CMD_OP_LSB +: 8];
        cmd_q.unit <= fpad_unit_t'(pwdata[FPAD_CMD_UNIT_LSB +: 4]);
        cmd_q.x_signed <= pwdata[FPAD_CMD_XS_BIT];
        cmd_q.y_signed <= pwdata[FPAD_CMD_YS_BIT];
        cmd_q.round <= pwdata[FPAD_CMD_RND_BIT];
        cmd_q.amount <= pwdata[FPAD_CMD_AMT_LSB +: 6];
        go_q <= 1'b1;
      end
    end
  end

  // ALU combinational result
  logic [16:0] alu_sum;  // Carry in bit 16
  logic [15:0] alu_a;  // Effective first addend
  logic [15:0] alu_b;  // Effective second addend
  logic alu_cin;  // Effective carry in
  logic alu_arith;  // Operation uses adder and its flags
  logic [15:0] alu_r;  // Result pattern
  logic alu_ovf;  // Overflow
  logic alu_quot;  // Quotient bit for divide steps
  always_comb begin
    alu_a = x_q;
    alu_b = y_q;
    alu_cin = 1'b0;
    alu_arith = 1'b1;
    alu_quot = arith_status_reg_q.quot;
    case (cmd_q.op)
      FPAD_A_ADD: begin
      end
      FPAD_A_ADC: alu_cin = arith_status_reg_q.carry_flag;
      FPAD_A_SUB: begin alu_b = ~y_q; alu_cin = 1'b1; end
      FPAD_A_SBB: begin alu_b = ~y_q; alu_cin = arith_status_reg_q.carry_flag; end
      FPAD_A_RSUB: begin alu_a = ~x_q; alu_cin = 1'b1; end
      FPAD_A_RSBB: begin alu_a = ~x_q; alu_cin = arith_status_reg_q.carry_flag; end
      FPAD_A_NEGX: begin alu_a = ~x_q; alu_b = 16'h0000; alu_cin = 1'b1; end
      FPAD_A_NEGY: begin alu_a = 16'h0000; alu_b = ~y_q; alu_cin = 1'b1; end
      FPAD_A_INCY: begin alu_a = 16'h0000; alu_cin = 1'b1; end
      FPAD_A_DECY: alu_a = 16'hffff;
      FPAD_A_PASSX: alu_b = 16'h0000;
      FPAD_A_PASSY: alu_a = 16'h0000;
      FPAD_A_ZERO: begin alu_a = 16'h0000; alu_b = 16'h0000; end
      FPAD_A_ABSX: begin
        alu_a = x_q[15] ? ~x_q : x_q;
        alu_b = 16'h0000;
        alu_cin = x_q[15];
      end
      // signed step, sign taken from operands
      FPAD_A_SIGNED_DIVIDE_STEP: begin
        alu_quot = x_q[15] ^ y_q[15];
        alu_a = x_q;
        alu_b = 16'h0000;
      end
      // unsigned step, add or subtract by quotient
      FPAD_A_DIVQ: begin
        alu_b = arith_status_reg_q.quot ? y_q : ~y_q;
        alu_cin = !arith_status_reg_q.quot;
        alu_quot = x_q[15] ^ y_q[15];
      end
      default: alu_arith = 1'b0;
    endcase
    alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {16'h0000, alu_cin};
    case (cmd_q.op)
      FPAD_A_AND: alu_r = x_q & y_q;
      FPAD_A_OR: alu_r = x_q | y_q;
      FPAD_A_XOR: alu_r = x_q ^ y_q;
      FPAD_A_NOTX: alu_r = ~x_q;
      FPAD_A_NOTY: alu_r = ~y_q;
      default: alu_r = alu_sum[15:0];
    endcase
    // signs of addends agree but result differs
    alu_ovf = alu_arith && (alu_a[15] == alu_b[15]) && (alu_sum[15] != alu_a[15]);
  end

  // Multiplier: per-instruction operand signedness
  logic signed [16:0] mx;  // X extended by its signedness
  logic signed [16:0] my;  // Y extended by its signedness
  logic signed [33:0] prod_full;  // Exact product
  logic [31:0] prod;  // 32-bit product
  logic [39:0] prod_adj;  // Format-adjusted, extended product
  logic [39:0] mac_next;  // Next result register value
  logic mac_ovf;  // Upper guard bits disagree with sign
  always_comb begin
    mx = $signed({cmd_q.x_signed & x_q[15], x_q});
    my = $signed({cmd_q.y_signed & y_q[15], y_q});
    prod_full = mx * my;
    prod = prod_full[31:0];
    // signed product extended to 40 bits
    if (frac_mode_q) begin
      prod_adj = {{7{prod[31]}}, prod, 1'b0};
    end else begin
      prod_adj = {{8{prod[31]}}, prod};
    end
    case (cmd_q.op)
      FPAD_M_MAC: mac_next = mult_result_reg_q + prod_adj;
      FPAD_M_MSB: mac_next = mult_result_reg_q - prod_adj;
      FPAD_M_CLR: mac_next = 40'h00_0000_0000;
      default: mac_next = prod_adj;
    endcase
    // Rounding adds half an LSB of the 16-bit upper word
    if (cmd_q.round) begin
      mac_next = mac_next + {24'h000000, FPAD_RND_BIAS};
    end
    mac_ovf = (mac_next[39:31] != {9{mac_next[39]}});
  end

  // Shifter
  logic [15:0] shf_r;  // Shift result
  logic [5:0] exp_r;  // Redundant sign bits count
  always_comb begin
    shf_r = x_q;
    exp_r = 6'd15;  // All bits copy the sign unless one below differs
    case (cmd_q.op)
      FPAD_S_LSH: shf_r = x_q << cmd_q.amount[3:0];
      FPAD_S_ASH: shf_r = 16'($signed(x_q) >>> cmd_q.amount[3:0]);
      default: shf_r = x_q;
    endcase
    // highest bit unlike the sign sets the count
    for (int i = 0; i <= 14; i++) begin
      if (x_q[i] != x_q[15]) begin
        exp_r = 6'(14 - i);
      end
    end
  end

  // Execute and capture results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_res_q <= 16'h0000;
      mult_result_reg_q <= 40'h00_0000_0000;
      shf_res_q <= 16'h0000;
      shf_exp_q <= 6'd0;
      arith_status_reg_q <= FPAD_RST_STATUS;
    end else if (go_q) begin
      if (cmd_q.unit == FPAD_UNIT_ALU) begin
        alu_res_q <= alu_r;
        // flags latched at end of cycle
        arith_status_reg_q.zero <= (alu_r == 16'h0000);
        arith_status_reg_q.negative_flag <= alu_r[15];
        arith_status_reg_q.carry_flag <= alu_arith & alu_sum[16];
        arith_status_reg_q.overflow_flag <= alu_ovf;
        arith_status_reg_q.x_sign <= x_q[15];
        arith_status_reg_q.quot <= alu_quot;
      end else if (cmd_q.unit == FPAD_UNIT_MAC) begin
        mult_result_reg_q <= mac_next;
        arith_status_reg_q.mac_ovf <= mac_ovf;
      end else if (cmd_q.unit == FPAD_UNIT_SHF) begin
        shf_res_q <= shf_r;
        shf_exp_q <= exp_r;
      end
    end
  end

  // Interrupt status and mask; set wins over write-one-to-clear
  logic [1:0] ev;
  assign ev[FPAD_IRQ_AOVF] = go_q && cmd_q.unit == FPAD_UNIT_ALU && alu_ovf;
  assign ev[FPAD_IRQ_MOVF] = go_q && cmd_q.unit == FPAD_UNIT_MAC && mac_ovf;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= FPAD_RST_IRQ;
      irq_mask_q <= FPAD_RST_IRQ;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == FPAD_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_en && paddr == FPAD_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[1:0];
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux, registered in setup so data is valid with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == FPAD_OFF_CMD) begin
        prdata <= {10'h000, cmd_q.amount, 1'b0, cmd_q.round, cmd_q.y_signed, cmd_q.x_signed,
                   cmd_q.unit, cmd_q.op};
      end else if (paddr == FPAD_OFF_OPS) begin
        prdata <= {y_q, x_q};
      end else if (paddr == FPAD_OFF_ALU_RES) begin
        prdata <= {16'h0000, alu_res_q};
      end else if (paddr == FPAD_OFF_STATUS) begin
        prdata <= {25'h0000000, arith_status_reg_q};
      end else if (paddr == FPAD_OFF_MULT_LO) begin
        // low word unsigned, high word sign-extended
        prdata <= mult_result_reg_q[31:0];
      end else if (paddr == FPAD_OFF_MULT_HI) begin
        prdata <= {{24{mult_result_reg_q[39]}}, mult_result_reg_q[39:32]};
      end else if (paddr == FPAD_OFF_SHF_RES) begin
        prdata <= {10'h000, shf_exp_q, shf_res_q};
      end else if (paddr == FPAD_OFF_IRQ_STAT) begin
        prdata <= {30'h00000000, irq_stat_q};
      end else if (paddr == FPAD_OFF_IRQ_MASK) begin
        prdata <= {30'h00000000, irq_mask_q};
      end else if (paddr == FPAD_OFF_MODE) begin
        prdata <= {31'h00000000, frac_mode_q};
      end else begin
        pslverr <= 1'b1;
      end
    end else begin  // Error stands for the access cycle only
      pslverr <= 1'b0;
    end
  end

  // fractional operands are 1.15; the datapath only fixes where the
  // product binary point lands, via the mode shift above.

endmodule

/* fpad_datapath_props.sv */
// Checker for the datapath's bus and interrupt ports.
// Assumes it is bound onto fpad_datapath and sees only its ports.
`timescale 1ns/1ps
module fpad_datapath_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  import fpad_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // Completed read, any address
  sequence s_read;
    psel && penable && pready && !pwrite;
  endsequence
  // Completed write clearing both mask bits
  sequence s_mask_off;
    psel && penable && pready && pwrite && paddr == FPAD_OFF_IRQ_MASK && pwdata[1:0] == 2'h0;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_pulse;
    pready |-> $past(psel) ##1 !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_idle;
    !psel |=> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("pready without select");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_err_data;
    s_read ##0 pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read data not zero");
  property p_irq_off;
    s_mask_off |-> ##2 !irq [*2];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_stat_rd;
    s_read ##0 (paddr == FPAD_OFF_STATUS) |-> prdata[31:7] == 25'h0;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status spare bits set");
  property p_hi_sext;
    s_read ##0 (paddr == FPAD_OFF_MULT_HI) |-> prdata[31:8] == {24{prdata[7]}};
  endproperty
  a_hi_sext: assert property (p_hi_sext) else $error("product top not sign-extended");
endmodule
bind fpad_datapath fpad_datapath_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

/* fpad_apb_master.sv */
// Bus master model standing in for the processor side of the datapath.
// Assumes one pclk; every signal changes just after a rising edge.
`timescale 1ns/1ps
module fpad_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; waits a bounded time for pready, flags a hang in to
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output bit to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : ~d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Read data taken only at the edge where pready is seen
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    to = (n >= 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* fixed_point_arith_formats_test.sv */
// Self-checking bench for the fixed-point datapath over its register bus.
// Assumes the bound checker and the bus master model in this folder.
`timescale 1ns/1ps
module fixed_point_arith_formats_test;
  import fpad_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rng = 32'h1900;
  logic [7:0] alu_ops [8] = '{FPAD_A_ADD, FPAD_A_SUB, FPAD_A_AND, FPAD_A_OR, FPAD_A_XOR, FPAD_A_NOTX, FPAD_A_NEGX,
    FPAD_A_ABSX};
  // Corner operands first, random ones after
  logic [31:0] corners [4] = '{32'h0001_7fff, 32'h0001_ffff, 32'h0001_8000, 32'h8000_8000};
  initial begin
    forever begin
      #2.5 pclk = ~pclk;
    end
  end
  fpad_apb_master i_bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fpad_datapath i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Expected {result, x sign, overflow, carry, negative, zero}
  function automatic logic [20:0] alu_exp(input logic [7:0] op, input logic [15:0] x, input logic [15:0] y);
    logic [16:0] s;
    logic v;
    case (op)
      FPAD_A_ADD: s = x + y;
      FPAD_A_SUB: s = {1'b0, x} + {1'b0, ~y} + 17'h1;
      FPAD_A_AND: s = {1'b0, x & y};
      FPAD_A_OR: s = {1'b0, x | y};
      FPAD_A_XOR: s = {1'b0, x ^ y};
      // Twos-complement negation is the inverse plus one
      FPAD_A_NEGX: s = {1'b0, ~x} + 17'h1;
      FPAD_A_ABSX: s = x[15] ? {1'b0, ~x} + 17'h1 : {1'b0, x};
      default: s = {1'b0, ~x};
    endcase
    // Only the most negative word overflows when negated
    v = op == FPAD_A_ADD ? x[15] == y[15] && s[15] != x[15] :
        op == FPAD_A_SUB ? x[15] != y[15] && s[15] != x[15] :
        (op == FPAD_A_NEGX || op == FPAD_A_ABSX) && x == 16'h8000;
    return {s[15:0], x[15], v, s[16], s[15], s[15:0] == 16'h0};
  endfunction
  // Product as signed, sign-extended to 40 bits, doubled in fractional mode
  function automatic logic [39:0] mac_exp(input logic [15:0] x, input logic [15:0] y, input logic [1:0] sg,
                                           input logic frac);
    logic signed [33:0] p;
    logic [39:0] e;
    p = $signed({sg[0] & x[15], x}) * $signed({sg[1] & y[15], y});
    e = {{8{p[31]}}, p[31:0]};
    return frac ? e << 1 : e;
  endfunction
  // Copies of the sign bit directly below it, for block floating-point
  function automatic logic [5:0] sign_run(input logic [15:0] x);
    int n;
    n = 0;
    while (n < 15 && x[14 - n] == x[15]) begin
      n++;
    end
    return 6'(n);
  endfunction
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    bit to;
    i_bus.xfer(w, a, d, r, e, to);
    if (to) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask
  // Operands, then the command word
  task automatic run(input logic [3:0] u, input logic [7:0] op, input logic [31:0] xy, input logic [1:0] sg,
                     input logic [5:0] amt);
    wr(FPAD_OFF_OPS, xy);
    wr(FPAD_OFF_CMD, {10'h000, amt, 2'b00, sg, u, op});
  endtask
  initial begin
    logic [31:0] r, h, xy;
    logic e;
    logic [7:0] op;
    logic [1:0] sg;
    logic [39:0] m, n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    bus(1'b0, FPAD_OFF_STATUS, 32'h0, r, e);
    chk("status_rst", r, FPAD_RST_STATUS);
    bus(1'b0, FPAD_OFF_MODE, 32'h0, r, e);
    chk("mode_rst", r[0], FPAD_RST_MODE);
    // Unmapped place refused
    bus(1'b0, 8'h28, 32'h0, r, e);
    chk("unmapped", {e, r}, 33'h1_0000_0000);
    // ALU results and flags
    for (int i = 0; i < 64; i++) begin
      xy = i < 32 ? corners[i % 4] : rnd();
      op = alu_ops[i < 32 ? i / 4 : rnd() % 8];
      run(FPAD_UNIT_ALU, op, xy, 2'b00, 6'h0);
      bus(1'b0, FPAD_OFF_ALU_RES, 32'h0, r, e);
      bus(1'b0, FPAD_OFF_STATUS, 32'h0, h, e);
      chk("alu", {r[15:0], h[4:0]}, alu_exp(op, xy[15:0], xy[31:16]));
    end
    // Signed divide step: quotient bit is the sign of the quotient
    for (int i = 2; i < 4; i++) begin
      run(FPAD_UNIT_ALU, FPAD_A_SIGNED_DIVIDE_STEP, corners[i], 2'b00, 6'h0);
      bus(1'b0, FPAD_OFF_STATUS, 32'h0, h, e);
      chk("signed_divide_step_quot", h[FPAD_ST_QUOT], corners[i][15] ^ corners[i][31]);
    end
    // Multiply in both formats, all signedness combinations
    for (int i = 0; i < 32; i++) begin
      xy = i < 8 ? corners[3] : rnd();
      sg = i[1:0];
      wr(FPAD_OFF_MODE, {31'h0, i[2]});
      run(FPAD_UNIT_MAC, FPAD_M_MUL, xy, sg, 6'h0);
      m = mac_exp(xy[15:0], xy[31:16], sg, i[2]);
      // Multiply, add, subtract: MR goes p, 2p, p
      for (int k = 0; k < 3; k++) begin
        if (k > 0) begin
          run(FPAD_UNIT_MAC, k == 1 ? FPAD_M_MAC : FPAD_M_MSB, xy, sg, 6'h0);
        end
        bus(1'b0, FPAD_OFF_MULT_LO, 32'h0, r, e);
        bus(1'b0, FPAD_OFF_MULT_HI, 32'h0, h, e);
        n = k == 1 ? m << 1 : m;
        chk("mac", {h[7:0], r}, n);
        chk("mac_hi", h[31:8], {24{n[39]}});
      end
      // Rounding variant, then clear, on the same operands
      wr(FPAD_OFF_CMD, {16'h0000, 2'b01, sg, FPAD_UNIT_MAC, FPAD_M_MUL});
      bus(1'b0, FPAD_OFF_MULT_LO, 32'h0, r, e);
      bus(1'b0, FPAD_OFF_MULT_HI, 32'h0, h, e);
      chk("mac_rnd", {h[7:0], r}, m + {24'h000000, FPAD_RND_BIAS});
      wr(FPAD_OFF_CMD, {16'h0000, 2'b00, sg, FPAD_UNIT_MAC, FPAD_M_CLR});
      bus(1'b0, FPAD_OFF_MULT_LO, 32'h0, r, e);
      chk("mac_clr", r, 32'h0);
    end
    // Logical left, arithmetic right, exponent only; exponent updates on all
    for (int i = 0; i < 36; i++) begin
      xy = i < 4 ? corners[i] : rnd();
      op = i % 3 == 2 ? FPAD_S_EXP : (i[0] ? FPAD_S_ASH : FPAD_S_LSH);
      run(FPAD_UNIT_SHF, op, xy, 2'b00, i[5:0] % 16);
      bus(1'b0, FPAD_OFF_SHF_RES, 32'h0, r, e);
      h = i[0] ? {16'h0, $signed(xy[15:0]) >>> (i % 16)} : {16'h0, xy[15:0] << (i % 16)};
      if (op != FPAD_S_EXP) begin
        chk("shift", r[15:0], h[15:0]);
      end
      chk("exp", r[21:16], sign_run(xy[15:0]));
    end
    // Overflow event: sticky, masked, cleared by a one
    wr(FPAD_OFF_IRQ_MASK, 32'h0);
    wr(FPAD_OFF_IRQ_STAT, 32'h3);
    run(FPAD_UNIT_ALU, FPAD_A_ADD, corners[0], 2'b00, 6'h0);
    bus(1'b0, FPAD_OFF_IRQ_STAT, 32'h0, r, e);
    chk("irq_stat", {r[0], irq}, 2'b10);
    wr(FPAD_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    wr(FPAD_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", irq, 1'b0);
    end_of_test();
  end
endmodule
